// >>> ucpb_top.sv
/*
 * ucpb_top: register file for two serial channels (phase, polarity,
 * mode, char size, baud divisor) on avalon-mm, plus a synchronous /
 * master spi frame engine for channel 0 clocked by link_clk.
 * assumes: reset_n asynchronous active low; link_clk free running;
 * receive_pin is asynchronous to both clocks.
 */
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - spi phase picks leading or trailing sample
// - sync: polarity swaps change and sample edges
// - spi polarity sets idle clock level
// - 16-bit divisor, low byte then high byte
// - divisor per channel, stride eight, resets zero
// - char size codes give 5..9 bits
// - mode field: async, sync, reserved, spi
// - spi data order selects lsb or msb first
module ucpb_top #(
    parameter int ADDR_W   = 12, // byte address width
    parameter int CHANNELS = 2   // register channels
) (
    // clock, reset, enable
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output var  logic [31:0]       readdata,
    output var  logic              waitrequest,
    // serial link, channel 0
    input  wire logic              link_clk,
    input  wire logic              receive_pin,
    output var  logic              transmit_pin,
    output var  logic              transmit_pin_oe,
    output var  logic              usart_serial_clock,
    output var  logic              usart_serial_clock_oe
);
    // refuse configurations the decode cannot serve
    if (CHANNELS < 1 || CHANNELS > 2 || ADDR_W < 12) begin : g_bad_param
        $error("ucpb_top: CHANNELS must be 1..2 and ADDR_W at least 12");
    end

    // reset release, bus domain
    logic rst_meta_reg, rst_n;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // ---------------- bus domain ----------------
    logic [7:0]          frame_ctrl_reg [CHANNELS]; // mode / phase / polarity
    logic [7:0]          char_ext_reg   [CHANNELS]; // char size bit 2
    logic [15:0]         baud_reg       [CHANNELS]; // baud divisor
    logic                ack_reg;                   // second cycle of access
    logic                busy_reg;                  // frame in flight
    logic                tx8_reg;                   // ninth transmit bit
    logic [8:0]          rx_data_reg;               // last received word
    logic                req_tog_reg;               // job request toggle
    ucpb_pkg::ucpb_job_s job_hold_reg;              // stable job for link side
    logic                done_meta_reg, done_sync_reg, done_seen_reg;
    logic                ldone_tog_reg;             // link side done toggle
    logic [8:0]          rx_word_reg;               // link side received word

    // address decode: channel by index range, offset within channel
    logic [9:0] word_idx, rel;
    logic       ch_sel, hit, wr_commit;
    assign word_idx  = address[11:2];
    assign ch_sel    = word_idx >= ucpb_pkg::IDX_CH1_FIRST;
    assign rel       = word_idx - (ch_sel ? 10'(ucpb_pkg::CH_STRIDE) : 10'h000);
    assign hit       = (!ch_sel || CHANNELS > 1) && rel >= ucpb_pkg::IDX_CHAR_EXT
                       && rel <= ucpb_pkg::IDX_STATUS && (address >> 12) == '0;
    assign wr_commit = write && ack_reg && clk_en;
    // waiting until the registered answer is ready
    assign waitrequest = (read || write) && !(ack_reg && clk_en);

    // access sequencing and read data, one wait cycle per access
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg  <= 1'b0;
            readdata <= 32'h0000_0000;
        end else if (clk_en) begin
            ack_reg <= (read || write) && !ack_reg;
            if (read && !ack_reg) begin
                readdata <= 32'h0000_0000; // unmapped reads as zero
                if (hit) begin
                    case (rel)
                        ucpb_pkg::IDX_CHAR_EXT:   readdata[7:0] <= char_ext_reg[ch_sel];
                        ucpb_pkg::IDX_FRAME_CTRL: readdata[7:0] <= frame_ctrl_reg[ch_sel];
                        ucpb_pkg::IDX_BAUD_LO:    readdata[7:0] <= baud_reg[ch_sel][7:0];
                        ucpb_pkg::IDX_BAUD_HI:    readdata[7:0] <= baud_reg[ch_sel][15:8];
                        ucpb_pkg::IDX_DATA:       readdata[7:0] <= ch_sel ? 8'h00
                                                                 : rx_data_reg[7:0];
                        ucpb_pkg::IDX_STATUS:     readdata[2:0] <= ch_sel ? 3'h0
                                                  : {tx8_reg, rx_data_reg[8], busy_reg};
                        default:                  readdata <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // configuration registers, both channels
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < CHANNELS; c++) begin
                frame_ctrl_reg[c] <= ucpb_pkg::FRAME_CTRL_RST;
                char_ext_reg[c]   <= ucpb_pkg::CHAR_EXT_RST;
                baud_reg[c]       <= ucpb_pkg::BAUD_RST;
            end
            tx8_reg <= 1'b0;
        end else if (wr_commit && byteenable[0] && hit) begin
            case (rel)
                ucpb_pkg::IDX_CHAR_EXT:
                    char_ext_reg[ch_sel] <= writedata[7:0] & 8'h04;
                ucpb_pkg::IDX_FRAME_CTRL:
                    frame_ctrl_reg[ch_sel] <= writedata[7:0];
                ucpb_pkg::IDX_BAUD_LO:
                    baud_reg[ch_sel][7:0] <= writedata[7:0];
                ucpb_pkg::IDX_BAUD_HI:
                    baud_reg[ch_sel][15:8] <= writedata[7:0];
                ucpb_pkg::IDX_STATUS:
                    if (!ch_sel) tx8_reg <= writedata[ucpb_pkg::ST_TX8];
                default: ;
            endcase
        end
    end

    // job launch and completion handshake toward the link side
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg      <= 1'b0;
            req_tog_reg   <= 1'b0;
            job_hold_reg  <= '0;
            rx_data_reg   <= 9'h000;
            done_meta_reg <= 1'b0;
            done_sync_reg <= 1'b0;
            done_seen_reg <= 1'b0;
        end else if (clk_en) begin
            done_meta_reg <= ldone_tog_reg;
            done_sync_reg <= done_meta_reg;
            done_seen_reg <= done_sync_reg;
            if (done_sync_reg != done_seen_reg) begin
                rx_data_reg <= rx_word_reg; // held stable by link side
                busy_reg    <= 1'b0;
            end else if (wr_commit && byteenable[0] && hit && !ch_sel
                         && rel == ucpb_pkg::IDX_DATA && !busy_reg) begin
                job_hold_reg.mode      <= ucpb_pkg::ucpb_mode_e'(
                                          frame_ctrl_reg[0][ucpb_pkg::MODE_LSB +: 2]);
                job_hold_reg.char_size <= {char_ext_reg[0][ucpb_pkg::BIT_CHAR2],
                                           frame_ctrl_reg[0][ucpb_pkg::BIT_ORDER],
                                           frame_ctrl_reg[0][ucpb_pkg::BIT_PHASE]};
                job_hold_reg.pol       <= frame_ctrl_reg[0][ucpb_pkg::BIT_POL];
                job_hold_reg.pha       <= frame_ctrl_reg[0][ucpb_pkg::BIT_PHASE];
                job_hold_reg.lsb_first <= frame_ctrl_reg[0][ucpb_pkg::BIT_ORDER];
                job_hold_reg.baud      <= baud_reg[0];
                job_hold_reg.data      <= {tx8_reg, writedata[7:0]};
                req_tog_reg            <= ~req_tog_reg;
                busy_reg               <= 1'b1;
            end
        end
    end

    // ---------------- link domain ----------------
    logic lrst_meta_reg, lrst_n;
    logic req_meta_reg, req_sync_reg, req_seen_reg;
    logic len_meta_reg, len_sync_reg;
    logic rx_meta_reg, rx_sync_reg;
    ucpb_pkg::ucpb_state_e state_reg;
    ucpb_pkg::ucpb_job_s   job_reg;      // job of the running frame
    logic [15:0]           half_cnt_reg; // link cycles in this half period
    logic [4:0]            edge_cnt_reg; // clock edges already made
    logic [3:0]            nbits_reg;    // data bits of this frame
    logic [8:0]            rx_sh_reg;    // receive assembly
    logic                  new_job, job_ok, accept_ev, tick, lead, sample_ev;
    logic                  eff_pha;
    logic [3:0]            bit_idx, next_idx;

    // bit position in the data word for transmit order
    function automatic logic [3:0] ucpb_pos(input logic [3:0] idx, input logic [3:0] nb,
                                            input logic lsb);
        ucpb_pos = lsb ? idx : nb - 4'h1 - idx;
    endfunction

    // link reset release and synchronisers
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            lrst_meta_reg <= 1'b0;
            lrst_n        <= 1'b0;
        end else begin
            lrst_meta_reg <= 1'b1;
            lrst_n        <= lrst_meta_reg;
        end
    end
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            {req_meta_reg, req_sync_reg} <= 2'b00;
            {len_meta_reg, len_sync_reg} <= 2'b00;
            {rx_meta_reg, rx_sync_reg}   <= 2'b11;
        end else begin
            {req_meta_reg, req_sync_reg} <= {req_tog_reg, req_meta_reg};
            {len_meta_reg, len_sync_reg} <= {clk_en, len_meta_reg};
            {rx_meta_reg, rx_sync_reg}   <= {receive_pin, rx_meta_reg};
        end
    end

    // job acceptance; async and reserved codes complete with no frame
    assign new_job   = req_sync_reg != req_seen_reg;
    assign job_ok    = job_hold_reg.mode == ucpb_pkg::UCPB_MSPI ||
                       (job_hold_reg.mode == ucpb_pkg::UCPB_SYNC &&
                        ucpb_pkg::ucpb_bits(job_hold_reg.char_size) != 4'h0);
    assign accept_ev = len_sync_reg && state_reg == ucpb_pkg::UCPB_IDLE && new_job && job_ok;
    // sync mode changes on the leading edge and samples on the trailing one
    assign eff_pha   = job_reg.mode == ucpb_pkg::UCPB_MSPI ? job_reg.pha : 1'b1;
    assign tick      = state_reg == ucpb_pkg::UCPB_RUN && half_cnt_reg == job_reg.baud;
    assign lead      = !edge_cnt_reg[0];
    assign sample_ev = tick && (lead != eff_pha);
    assign bit_idx   = edge_cnt_reg[4:1];
    assign next_idx  = bit_idx + {3'h0, !eff_pha};

    // frame engine
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            state_reg          <= ucpb_pkg::UCPB_IDLE;
            job_reg            <= '0;
            req_seen_reg       <= 1'b0;
            half_cnt_reg       <= 16'h0000;
            edge_cnt_reg       <= 5'h00;
            nbits_reg          <= 4'h0;
            rx_sh_reg          <= 9'h000;
            rx_word_reg        <= 9'h000;
            ldone_tog_reg      <= 1'b0;
            usart_serial_clock <= 1'b0;
            transmit_pin       <= 1'b1;
        end else if (len_sync_reg) begin
            case (state_reg)
                ucpb_pkg::UCPB_IDLE: begin
                    // clock rests at the polarity level; a new job takes its own level
                    usart_serial_clock <= new_job ? job_hold_reg.pol : job_reg.pol;
                    transmit_pin       <= 1'b1;
                    if (new_job) begin
                        req_seen_reg <= req_sync_reg;
                        job_reg      <= job_hold_reg;
                        half_cnt_reg <= 16'h0000;
                        edge_cnt_reg <= 5'h00;
                        state_reg    <= job_ok ? ucpb_pkg::UCPB_RUN : ucpb_pkg::UCPB_DONE;
                        nbits_reg    <= job_hold_reg.mode == ucpb_pkg::UCPB_MSPI
                                        ? ucpb_pkg::MSPI_BITS
                                        : ucpb_pkg::ucpb_bits(job_hold_reg.char_size);
                        // phase zero presents the first bit before any edge
                        if (job_ok && job_hold_reg.mode == ucpb_pkg::UCPB_MSPI
                            && !job_hold_reg.pha)
                            transmit_pin <= job_hold_reg.data[ucpb_pos(4'h0,
                                            ucpb_pkg::MSPI_BITS, job_hold_reg.lsb_first)];
                    end
                end
                ucpb_pkg::UCPB_RUN: begin
                    half_cnt_reg <= tick ? 16'h0000 : half_cnt_reg + 16'h0001;
                    if (tick) begin
                        usart_serial_clock <= ~usart_serial_clock;
                        edge_cnt_reg       <= edge_cnt_reg + 5'h01;
                        if (sample_ev) begin
                            rx_sh_reg[ucpb_pos(bit_idx, nbits_reg, job_reg.lsb_first
                                      || job_reg.mode == ucpb_pkg::UCPB_SYNC)] <= rx_sync_reg;
                        end else if (next_idx < nbits_reg) begin
                            // sync frames go out lsb first; spi follows the order bit
                            transmit_pin <= job_reg.data[ucpb_pos(next_idx, nbits_reg,
                                            job_reg.lsb_first
                                            || job_reg.mode == ucpb_pkg::UCPB_SYNC)];
                        end
                        if (edge_cnt_reg == 5'({nbits_reg, 1'b0} - 5'h01))
                            state_reg <= ucpb_pkg::UCPB_DONE;
                    end
                end
                ucpb_pkg::UCPB_DONE: begin
                    rx_word_reg   <= rx_sh_reg;
                    ldone_tog_reg <= ~ldone_tog_reg;
                    transmit_pin  <= 1'b1;
                    state_reg     <= ucpb_pkg::UCPB_IDLE;
                end
                default: state_reg <= ucpb_pkg::UCPB_IDLE;
            endcase
        end
    end

    // pin drive enables follow the mode of the last job
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            transmit_pin_oe       <= 1'b0;
            usart_serial_clock_oe <= 1'b0;
        end else if (len_sync_reg) begin
            transmit_pin_oe       <= job_reg.mode == ucpb_pkg::UCPB_SYNC
                                     || job_reg.mode == ucpb_pkg::UCPB_MSPI;
            usart_serial_clock_oe <= job_reg.mode == ucpb_pkg::UCPB_SYNC
                                     || job_reg.mode == ucpb_pkg::UCPB_MSPI;
        end
    end

    // ---------------- checks ----------------
    chk_baud_high_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_commit && byteenable[0] && hit && rel == ucpb_pkg::IDX_BAUD_HI
        |=> baud_reg[$past(ch_sel)][15:8] == $past(writedata[7:0]))
        else $error("baud high byte not stored");
    chk_baud_reset_zero: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> baud_reg[0] == 16'h0000)
        else $error("baud divisor not zero after reset");
    chk_sync_sample_edge: assert property (@(posedge link_clk) disable iff (!lrst_n)
        sample_ev && len_sync_reg && job_reg.mode == ucpb_pkg::UCPB_SYNC
        |=> usart_serial_clock == job_reg.pol)
        else $error("sync sample on wrong clock edge");
    chk_spi_idle_level: assert property (@(posedge link_clk) disable iff (!lrst_n)
        state_reg == ucpb_pkg::UCPB_IDLE && len_sync_reg ##1 state_reg == ucpb_pkg::UCPB_IDLE
        |-> usart_serial_clock == $past(job_reg.pol))
        else $error("idle clock level differs from polarity");
    chk_phase_lead_sample: assert property (@(posedge link_clk) disable iff (!lrst_n)
        sample_ev && len_sync_reg && job_reg.mode == ucpb_pkg::UCPB_MSPI && !job_reg.pha
        |=> usart_serial_clock != job_reg.pol)
        else $error("phase zero did not sample on leading edge");
    chk_phase_trail_sample: assert property (@(posedge link_clk) disable iff (!lrst_n)
        sample_ev && len_sync_reg && job_reg.mode == ucpb_pkg::UCPB_MSPI && job_reg.pha
        |=> usart_serial_clock == job_reg.pol)
        else $error("phase one did not sample on trailing edge");
    chk_char_size_five: assert property (@(posedge link_clk) disable iff (!lrst_n)
        accept_ev && job_hold_reg.mode == ucpb_pkg::UCPB_SYNC && job_hold_reg.char_size == 3'h0
        |=> nbits_reg == 4'h5 && state_reg == ucpb_pkg::UCPB_RUN)
        else $error("five bit code not decoded");
    // edge counter bounds every frame, so a run always reaches done
    chk_frame_edge_bound: assert property (@(posedge link_clk) disable iff (!lrst_n)
        state_reg == ucpb_pkg::UCPB_RUN |-> edge_cnt_reg <= 5'({nbits_reg, 1'b0} - 5'h01))
        else $error("frame ran past its last clock edge");
    chk_mode_reserved: assert property (@(posedge link_clk) disable iff (!lrst_n)
        len_sync_reg && state_reg == ucpb_pkg::UCPB_IDLE && new_job
        && job_hold_reg.mode == ucpb_pkg::UCPB_RSVD |=> state_reg == ucpb_pkg::UCPB_DONE)
        else $error("reserved mode started a frame");
    chk_spi_first_bit: assert property (@(posedge link_clk) disable iff (!lrst_n)
        accept_ev && job_hold_reg.mode == ucpb_pkg::UCPB_MSPI && !job_hold_reg.pha
        |=> transmit_pin == (job_reg.lsb_first ? job_reg.data[0] : job_reg.data[7]))
        else $error("first spi bit ignores data order");
    cov_spi_frame: cover property (@(posedge link_clk) disable iff (!lrst_n)
        accept_ev && job_hold_reg.mode == ucpb_pkg::UCPB_MSPI);
    cov_sync_frame: cover property (@(posedge link_clk) disable iff (!lrst_n)
        accept_ev && job_hold_reg.mode == ucpb_pkg::UCPB_SYNC);
    cov_frame_done: cover property (@(posedge ref_clk) disable iff (!rst_n)
        busy_reg ##1 !busy_reg);
endmodule // ucpb_top
`default_nettype wire

// >>> ucpb_pkg.sv
/*
 * ucpb_pkg: constants, types and shared decode for the usart clock
 * phase / polarity and baud divisor slice.
 * assumes: included by name as ucpb_pkg:: from the design files and the testbench.
 */
`default_nettype none
package ucpb_pkg;
    // register indices; byte address on the bus is four times the index
    localparam int         CH_STRIDE      = 8;       // index spacing per channel
    localparam logic [9:0] IDX_CHAR_EXT   = 10'h0c1; // char size extension bit
    localparam logic [9:0] IDX_FRAME_CTRL = 10'h0c2; // mode, size/order, phase, polarity
    localparam logic [9:0] IDX_BAUD_LO    = 10'h0c4; // baud divisor [7:0]
    localparam logic [9:0] IDX_BAUD_HI    = 10'h0c5; // baud divisor [15:8]
    localparam logic [9:0] IDX_DATA       = 10'h0c6; // write starts frame, read rx
    localparam logic [9:0] IDX_STATUS     = 10'h0c7; // busy, rx bit 8, tx bit 8
    localparam logic [9:0] IDX_CH1_FIRST  = 10'h0c8; // first index of channel 1
    // reset values
    localparam logic [7:0]  FRAME_CTRL_RST = 8'h06;
    localparam logic [7:0]  CHAR_EXT_RST   = 8'h00;
    localparam logic [15:0] BAUD_RST       = 16'h0000;
    // field positions
    localparam int MODE_LSB  = 6; // two-bit operating mode field
    localparam int BIT_ORDER = 2; // char size bit 1 / data order
    localparam int BIT_PHASE = 1; // char size bit 0 / clock phase
    localparam int BIT_POL   = 0; // clock polarity
    localparam int BIT_CHAR2 = 2; // char size bit 2 in extension register
    localparam int ST_BUSY   = 0;
    localparam int ST_RX8    = 1;
    localparam int ST_TX8    = 2;
    // frame length of master spi emulation
    localparam logic [3:0] MSPI_BITS = 4'h8;

    // operating mode field codes
    typedef enum logic [1:0] {
        UCPB_ASYNC = 2'b00,
        UCPB_SYNC  = 2'b01,
        UCPB_RSVD  = 2'b10,
        UCPB_MSPI  = 2'b11
    } ucpb_mode_e;

    // link engine states, gray along idle -> run -> done
    typedef enum logic [1:0] {
        UCPB_IDLE = 2'b00,
        UCPB_RUN  = 2'b01,
        UCPB_DONE = 2'b11
    } ucpb_state_e;

    // one frame job handed from the bus side to the link side
    typedef struct packed {
        ucpb_mode_e  mode;
        logic [2:0]  char_size;
        logic        pol;
        logic        pha;
        logic        lsb_first;
        logic [15:0] baud;
        logic [8:0]  data;
    } ucpb_job_s;

    // char size code to data bits; zero marks a reserved code
    function automatic logic [3:0] ucpb_bits(input logic [2:0] code);
        case (code)
            3'h0:    ucpb_bits = 4'h5;
            3'h1:    ucpb_bits = 4'h6;
            3'h2:    ucpb_bits = 4'h7;
            3'h3:    ucpb_bits = 4'h8;
            3'h7:    ucpb_bits = 4'h9;
            default: ucpb_bits = 4'h0;
        endcase
    endfunction
endpackage
`default_nettype wire

// >>> ucpb_remote_slave.sv
/* ucpb_remote_slave: far-side spi / synchronous peer, behavioural.
   assumes: the bench pulses arm with the frame setup before each frame. */
`timescale 1ns/10ps
`default_nettype none
module ucpb_remote_slave (
    // serial pins
    input  wire logic       sclk,
    input  wire logic       mosi,
    output var  logic       miso,
    // frame setup
    input  wire logic       arm,
    input  wire logic       pol,
    input  wire logic       pha,
    input  wire logic       lsb,
    input  wire logic [7:0] tx_byte,
    output var  logic [7:0] rx_byte
);
    int idx = 99;    // bit index, out of range when idle except after a phase 1 frame
    bit led = 1'b0;  // leading edge seen this frame
    // new frame: phase 0 shows bit 0 at once
    always @(posedge arm) begin
        idx = pha ? -1 : 0;
        led = 1'b0;
    end
    // leading edge leaves the idle level, trailing returns to it
    always @(sclk) begin
        if (sclk !== pol) begin
            led = 1'b1;
            if (pha) idx++;
            else rx_byte[lsb ? idx : 7 - idx] = mosi;
        end else if (led) begin
            // idle-level jumps before any leading edge are ignored
            if (pha) rx_byte[lsb ? idx : 7 - idx] = mosi;
            else idx++;
        end
    end
    // outside a frame the line toggles, except after a phase 1 frame, which leaves the last bit
    assign miso = (idx >= 0 && idx < 8) ? tx_byte[lsb ? idx : 7 - idx] : ~sclk;
endmodule // ucpb_remote_slave
`default_nettype wire

// >>> testbench.sv
/* testbench: registers and serial frames of ucpb_top against a model.
   assumes: ucpb_pkg compiled first, peer model ucpb_remote_slave. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [9:0] LO = ucpb_pkg::IDX_BAUD_LO;
    localparam logic [9:0] CTRL = ucpb_pkg::IDX_FRAME_CTRL;
    logic        ref_clk = 0, link_clk = 0, reset_n = 0, read = 0, write = 0;
    logic [11:0] address = 12'h000;            // byte address
    logic [31:0] writedata = 32'h0, readdata;
    logic        waitrequest, txd, txd_oe, sclk, sclk_oe, miso, arm = 0;
    logic        pol = 0, pha = 0, lsb = 0;      // peer frame setup
    logic        clk_en = 1;                     // random stalls
    logic [7:0]  mask, old_peer = 8'h00, old_dut = 8'h00; // expected rx history
    logic [7:0]  tx_byte = 8'h00, rx_byte, rd, wd;
    logic [7:0]  model [int];                  // register model by index
    int          errors = 0, comparisons = 0, n;
    ucpb_top i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(4'h1), .readdata(readdata), .waitrequest(waitrequest),
        .link_clk(link_clk), .receive_pin(miso), .transmit_pin(txd),
        .transmit_pin_oe(txd_oe), .usart_serial_clock(sclk),
        .usart_serial_clock_oe(sclk_oe));
    ucpb_remote_slave i_peer (.sclk(sclk), .mosi(txd), .miso(miso), .arm(arm),
        .pol(pol), .pha(pha), .lsb(lsb), .tx_byte(tx_byte), .rx_byte(rx_byte));
    // clocks, unrelated phases
    initial forever #10 ref_clk = ~ref_clk;
    initial begin
        #3;
        forever #6 link_clk = ~link_clk;
    end
    // random stalls through the clock enable
    always @(posedge ref_clk) clk_en <= ($urandom % 8) != 0;
    // compare and count
    task automatic check(input string name, input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one avalon cycle, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wdat);
        int k;
        @(posedge ref_clk);
        address <= {idx, 2'b00};
        write <= wr;
        read <= ~wr;
        writedata <= {24'h0, wdat};
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        if (k >= 50) errors++;
        rd = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // verdict and end of run
    task automatic stop_test();
        if (errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // hang guard
    initial begin
        #1_000_000;
        errors++;
        stop_test();
    end
    // main sequence
    initial begin
        void'($urandom(32'hd2d4));
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        // reset values, then random divisors per channel
        for (int i = 0; i < 4; i++) begin
            bus(0, LO + 10'(8 * (i / 2) + i % 2), 8'h00);
            check("baud_rst", rd, 8'h00);
            model[i] = 8'($urandom);
            bus(1, LO + 10'(8 * (i / 2) + i % 2), model[i]);
        end
        for (int i = 0; i < 4; i++) begin
            bus(0, LO + 10'(8 * (i / 2) + i % 2), 8'h00);
            check("baud", rd, model[i]);
        end
        bus(1, 10'h0c3, 8'h5a);
        bus(0, 10'h0c3, 8'h00);
        check("unmapped", rd, 8'h00);
        // spi in every phase/polarity/order mix, sync 8 and 5 bits, async, reserved
        for (int k = 0; k < 12; k++) begin
            pha <= k < 8 ? k[0] : 1'b1;
            pol <= k < 8 ? k[1] : k[0];
            lsb <= k < 8 ? k[2] : 1'b1;
            mask = k < 9 ? 8'hff : (k == 9 ? 8'h1f : 8'h00); // bits a frame replaces
            tx_byte <= 8'($urandom);
            bus(1, LO, 8'(3 + $urandom % 5));
            bus(1, LO + 10'h001, 8'h00);
            bus(1, CTRL, {(k < 8 ? 2'b11 : (k < 10 ? 2'b01 : {k[0], 1'b0})), 3'b000,
                (k == 9 ? 2'b00 : {lsb, pha}), pol});
            arm <= 1'b1;
            @(posedge ref_clk);
            arm <= 1'b0;
            wd = 8'($urandom);
            bus(1, ucpb_pkg::IDX_DATA, wd);
            rd = 8'h01;
            for (n = 0; n < 300 && rd[0] !== 1'b0; n++) bus(0, ucpb_pkg::IDX_STATUS, 8'h00);
            if (n >= 300) errors++;
            old_peer = (wd & mask) | (old_peer & ~mask);
            old_dut = (tx_byte & mask) | (old_dut & ~mask);
            check("peer_rx", rx_byte, old_peer);
            bus(0, ucpb_pkg::IDX_DATA, 8'h00);
            check("dut_rx", rd, old_dut);
            check("sclk_idle", {7'h00, sclk}, {7'h00, pol});
            check("pin_oe", {6'h00, txd_oe, sclk_oe}, k < 10 ? 8'h03 : 8'h00);
        end
        stop_test();
    end
endmodule // testbench
`default_nettype wire
